// *** hdl/comparator_map.svh ***
// register map, field positions and reset values of the comparator control block
//
// Contract
// - module_enable, bit 7, turns the comparator on; zero holds it disabled.
// - reference_select, bit 6, picks plus pin (0) or internal bandgap (1).
// - event_flag, bit 5, is set by hardware on the selected compare event.
// - event_flag clears only when software writes one to bit 5.
// - event_irq_enable, bit 4, raises the interrupt request while the flag is set.
// - compare_result, bit 3, reads the live result; zero while disabled.
// - result_pin_enable, bit 2, drives the result onto result_pin; else undriven.
// - edge_select bits 1:0: 00 and 10 falling, 01 rising, 11 either edge.
// - the result is high when the plus input exceeds the minus input.
// - an enabled comparator keeps working in wait mode so it can wake the core.
// - the comparator is inactive in every stop mode and never wakes from stop.
// - the two deepest stop modes lose all state; block returns in reset state.
// - lightest stop halts clocks, keeps registers, no compare and no flagging.
// - lightest stop left by reset gives reset state; by interrupt resumes.
// - in background debug the block compares, flags and interrupts as normal.
// - capture_route_enable feeds the result to timer channel 0, hiding its pin.
// - one 8-bit register holds every control and status bit except capture_route_enable, which sits at offset 004.
`ifndef COMPARATOR_MAP_SVH
`define COMPARATOR_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CMP_STATUS_CONTROL_OFFSET 12'h000
`define CMP_SYSTEM_OPTIONS_OFFSET 12'h004
`define CMP_ADDR_WIDTH 12

// ----------------------------------------
// field positions
// ----------------------------------------
`define CMP_BIT_ENABLE 7
`define CMP_BIT_REF_SEL 6
`define CMP_BIT_FLAG 5
`define CMP_BIT_IRQ_EN 4
`define CMP_BIT_RESULT 3
`define CMP_BIT_PIN_EN 2
`define CMP_BIT_EDGE_HI 1
`define CMP_BIT_EDGE_LO 0
`define CMP_BIT_CAPTURE_ROUTE 0

// ----------------------------------------
// edge modes and reset values
// ----------------------------------------
`define CMP_EDGE_FALL_A 2'h0
`define CMP_EDGE_RISE 2'h1
`define CMP_EDGE_FALL_B 2'h2
`define CMP_EDGE_BOTH 2'h3
`define CMP_CTRL_RESET 8'h00
`define CMP_OPT_RESET 1'h0
`define CMP_SYNC_STAGES 2'h2

`endif

// *** hdl/comparator_pkg.sv ***
// types shared by the comparator control block
package comparator_pkg;

  // ----------------------------------------
  // power modes seen by the block
  // ----------------------------------------
  typedef enum logic [4:0] {
    PWR_RUN = 5'h01,
    PWR_WAIT = 5'h02,
    PWR_STOP_LIGHT = 5'h04,
    PWR_STOP_DEEP = 5'h08,
    PWR_DEBUG = 5'h10
  } power_mode_e;

  // ----------------------------------------
  // control fields of the status/control byte
  // ----------------------------------------
  typedef struct packed {
    logic module_enable;
    logic reference_select;
    logic event_irq_enable;
    logic result_pin_enable;
    logic [1:0] edge_select;
  } control_s;

  // ----------------------------------------
  // pin-side signals of the comparator
  // ----------------------------------------
  typedef struct packed {
    logic result_pin_o;
    logic result_pin_oe;
    logic capture_in;
    logic capture_pin_block;
  } pin_out_s;

endpackage

// *** hdl/result_sync.sv ***
// two-stage synchroniser with edge detection for the raw comparator result
module result_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire logic raw,
  // result
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // ----------------------------------------
  // synchroniser; the meta stage feeds only the second stage
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else if (!run) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= raw;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------
  // previous sample; cleared with run, so an input already high at enable gives one rise
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= 1'b0;
    end else if (!run) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise = run && sync_ff && !prev_ff;
  assign fall = run && !sync_ff && prev_ff;

endmodule // result_sync

// *** hdl/comparator_control.sv ***
// comparator control and status logic with apb register access
//
// Implementation choices: the address map and register access over APB.
`include "comparator_map.svh"

module comparator_control (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog core
  input wire logic analog_result,
  output logic core_enable,
  output logic reference_select,
  // power mode
  input wire comparator_pkg::power_mode_e power_mode,
  // pins and timer
  output comparator_pkg::pin_out_s pins,
  // interrupt
  output logic irq
);
  import comparator_pkg::*;

  control_s ctrl_ff;
  logic event_flag_ff;
  logic capture_route_ff;
  logic result_ff;
  logic stop_light;
  logic stop_deep;
  logic run;
  logic sync_level;
  logic rise;
  logic fall;
  logic [1:0] warm_ff;
  logic settled;
  logic edge_hit;
  logic wr_en;
  logic rd_en;
  logic hit_ctrl;
  logic hit_opt;
  logic clear_flag;
  logic [7:0] ctrl_byte;

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // wait and debug run as normal; only stop modes silence the comparator
  assign stop_light = (power_mode == PWR_STOP_LIGHT);
  assign stop_deep = (power_mode == PWR_STOP_DEEP);
  assign run = ctrl_ff.module_enable && !stop_light && !stop_deep;

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  // zero wait states; unmapped addresses answer with pslverr
  assign hit_ctrl = (paddr == `CMP_STATUS_CONTROL_OFFSET);
  assign hit_opt = (paddr == `CMP_SYSTEM_OPTIONS_OFFSET);
  assign wr_en = psel && penable && pwrite && pstrb[0] && (hit_ctrl || hit_opt);
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hit_ctrl || hit_opt);
  assign clear_flag = wr_en && hit_ctrl && pwdata[`CMP_BIT_FLAG];

  // ----------------------------------------
  // synchroniser and edge detection
  // ----------------------------------------
  result_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .run(run),
    .raw(analog_result),
    .level(sync_level),
    .rise(),
    .fall()
  );

  // ----------------------------------------
  // settle count after (re)start of the synchroniser
  // ----------------------------------------
  // the synchroniser restarts empty after a stop; until it is full its level
  // is not the core's, so the held result must not be compared against it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warm_ff <= 2'h0;
    end else if (!run) begin
      warm_ff <= 2'h0;
    end else if (warm_ff != `CMP_SYNC_STAGES) begin
      warm_ff <= warm_ff + 2'h1;
    end
  end

  assign settled = (warm_ff == `CMP_SYNC_STAGES);
  // edges against the last accepted sample, so light stop resumes cleanly
  assign rise = settled && sync_level && !result_ff;
  assign fall = settled && !sync_level && result_ff;

  always_comb begin
    case (ctrl_ff.edge_select)
      `CMP_EDGE_FALL_A: edge_hit = fall;
      `CMP_EDGE_RISE: edge_hit = rise;
      `CMP_EDGE_FALL_B: edge_hit = fall;
      `CMP_EDGE_BOTH: edge_hit = rise || fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // control fields
  // ----------------------------------------
  // deep stop powers the block down, so it comes back in reset state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= control_s'(6'h00);
    end else if (stop_deep) begin
      ctrl_ff <= control_s'(6'h00);
    end else if (stop_light) begin
      ctrl_ff <= ctrl_ff;
    end else if (wr_en && hit_ctrl) begin
      ctrl_ff.module_enable <= pwdata[`CMP_BIT_ENABLE];
      ctrl_ff.reference_select <= pwdata[`CMP_BIT_REF_SEL];
      ctrl_ff.event_irq_enable <= pwdata[`CMP_BIT_IRQ_EN];
      ctrl_ff.result_pin_enable <= pwdata[`CMP_BIT_PIN_EN];
      ctrl_ff.edge_select <= pwdata[`CMP_BIT_EDGE_HI:`CMP_BIT_EDGE_LO];
    end
  end

  // ----------------------------------------
  // system option bit for the capture route
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_route_ff <= `CMP_OPT_RESET;
    end else if (stop_deep) begin
      capture_route_ff <= `CMP_OPT_RESET;
    end else if (!stop_light && wr_en && hit_opt) begin
      capture_route_ff <= pwdata[`CMP_BIT_CAPTURE_ROUTE];
    end
  end

  // ----------------------------------------
  // event flag; a new event beats a clear in the same cycle
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_flag_ff <= 1'b0;
    end else if (stop_deep) begin
      event_flag_ff <= 1'b0;
    end else if (stop_light) begin
      event_flag_ff <= event_flag_ff;
    end else if (edge_hit) begin
      event_flag_ff <= 1'b1;
    end else if (clear_flag) begin
      event_flag_ff <= 1'b0;
    end
  end

  // ----------------------------------------
  // result bit; held frozen through light stop
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= 1'b0;
    end else if (stop_light) begin
      result_ff <= result_ff;
    end else if (!run) begin
      result_ff <= 1'b0;
    end else if (settled) begin
      result_ff <= sync_level;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  assign ctrl_byte = {ctrl_ff.module_enable, ctrl_ff.reference_select, event_flag_ff,
                      ctrl_ff.event_irq_enable, result_ff, ctrl_ff.result_pin_enable,
                      ctrl_ff.edge_select};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {24'h00_0000, ctrl_byte};
      end else if (hit_opt) begin
        prdata <= {31'h0000_0000, capture_route_ff};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end else if (rd_en) begin
      prdata <= prdata;
    end
  end

  // ----------------------------------------
  // outputs to core, pins, timer and interrupt
  // ----------------------------------------
  // the debug pin must be freed by software first; that is outside this block
  // the bandgap buffer must already be on when reference 1 is chosen
  assign core_enable = run;
  assign reference_select = ctrl_ff.reference_select;
  assign pins.result_pin_o = result_ff;
  assign pins.result_pin_oe = ctrl_ff.result_pin_enable && ctrl_ff.module_enable;
  assign pins.capture_in = capture_route_ff && result_ff;
  assign pins.capture_pin_block = capture_route_ff;
  // no wake from stop: request gated off in any stop mode
  assign irq = event_flag_ff && ctrl_ff.event_irq_enable && !stop_light && !stop_deep;

endmodule // comparator_control

// *** dv/analog_core_model.sv ***
// behavioural analog comparator core facing the control block
module analog_core_model #(
  parameter int bg_mv = 1200
) (
  // clock and control
  input wire logic pclk,
  input wire logic core_enable,
  input wire logic reference_select,
  // analog levels in millivolts
  input wire logic [15:0] plus_mv,
  input wire logic [15:0] minus_mv,
  // raw result
  output logic analog_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic idle_ff = 1'b0;
  // a powered-down core has no stable level, so it toggles to expose any use of it
  always @(posedge pclk) idle_ff <= ~idle_ff;
  assign analog_result = !core_enable ? idle_ff :
    ((reference_select ? bg_mv : int'(plus_mv)) > int'(minus_mv));
endmodule // analog_core_model

// *** dv/comparator_checker.sv ***
// assertions on the ports of the comparator control block
`include "comparator_map.svh"
module comparator_checker
  import comparator_pkg::*;
(
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core, power, pins
  input wire logic analog_result,
  input wire logic core_enable,
  input wire logic reference_select,
  input wire comparator_pkg::power_mode_e power_mode,
  input wire comparator_pkg::pin_out_s pins,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stop, acc, wr_c, wr_o, rd_c, off;
  assign stop = power_mode inside {PWR_STOP_LIGHT, PWR_STOP_DEEP};
  assign acc = psel && penable;
  assign wr_c = acc && pwrite && pstrb[0] && !stop && paddr == `CMP_STATUS_CONTROL_OFFSET;
  assign wr_o = acc && pwrite && pstrb[0] && !stop && paddr == `CMP_SYSTEM_OPTIONS_OFFSET;
  assign rd_c = psel && !penable && !pwrite && paddr == `CMP_STATUS_CONTROL_OFFSET;
  assign off = !core_enable && power_mode == PWR_RUN;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_stop_quiet: assert property (stop |-> !core_enable && !irq)
    else $error("core or irq active in stop");
  chk_en_write: assert property (wr_c |=> core_enable == ($past(pwdata[7]) && !stop))
    else $error("enable write not applied");
  chk_ref_write: assert property (wr_c |=> reference_select == $past(pwdata[6]))
    else $error("reference select write not applied");
  chk_pin_write: assert property (wr_c |=> pins.result_pin_oe == $past(pwdata[7] && pwdata[2]))
    else $error("pin enable mismatch");
  chk_route_write: assert property (wr_o |=> pins.capture_pin_block == $past(pwdata[0]))
    else $error("capture route write not applied");
  chk_route_off: assert property (!pins.capture_pin_block |-> !pins.capture_in)
    else $error("capture driven while not routed");
  chk_off_read: assert property (off [*3] ##0 rd_c |=> !prdata[3])
    else $error("result read high while disabled");
  chk_map_err: assert property (acc |-> pslverr == !(paddr inside {12'h000, 12'h004}))
    else $error("error response mismatch");
  cov_irq: cover property (irq);
  cov_stop: cover property (stop ##1 !stop);
  cov_route: cover property (pins.capture_in);
endmodule // comparator_checker

// *** dv/tb.sv ***
// self-checking bench for the comparator control block
`include "comparator_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import comparator_pkg::*;
  localparam logic [11:0] ctrl_a = `CMP_STATUS_CONTROL_OFFSET;
  localparam logic [11:0] opt_a = `CMP_SYSTEM_OPTIONS_OFFSET;
  localparam int bg_mv = 1200;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, analog_result, core_enable, reference_select, irq;
  power_mode_e power_mode = PWR_RUN;
  pin_out_s pins;
  logic [15:0] plus_mv = 16'h0000, minus_mv = 16'h01F4;
  int fails = 0, tests_run = 0, cyc = 0;
  // bench copy of the register fields and the live result
  logic en, rs, fl, ie, pe, rt, res;
  logic [1:0] es;
  always #5 pclk = ~pclk;
  comparator_control dut (.*);
  analog_core_model #(.bg_mv(bg_mv)) core (.pclk(pclk), .core_enable(core_enable),
    .reference_select(reference_select), .plus_mv(plus_mv), .minus_mv(minus_mv),
    .analog_result(analog_result));
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    cmp({31'h0, got}, {31'h0, exp});
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'($urandom()), d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    if (a == opt_a) rt = d[0];
    else {en, rs, ie, pe, es} = {d[7:6], d[4], d[2:0]};
    if (a == ctrl_a && d[5]) fl = 1'b0;
    res = res && en;
  endtask
  task automatic rd(input logic [11:0] a);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 8'h00, r, e);
    if (a == ctrl_a) cmp(r, {24'h0, en, rs, fl, ie, res, pe, es});
    else cmp(r, {31'h0, rt});
    cmp_bit(e, 1'b0);
    @(negedge pclk);
    cmp_bit(irq, fl && ie);
    cmp_bit(pins.result_pin_oe, pe && en);
    cmp_bit(pins.result_pin_o, res);
    cmp_bit(pins.capture_in, rt && res);
  endtask
  // new plus level, then the model settles after the synchroniser delay
  task automatic drive(input logic [15:0] p);
    logic prev;
    prev = res;
    @(posedge pclk);
    plus_mv <= p;
    repeat (5) @(posedge pclk);
    if (!(power_mode inside {PWR_STOP_LIGHT, PWR_STOP_DEEP})) begin
      res = en && ((rs ? bg_mv : int'(p)) > int'(minus_mv));
      if (en && res != prev && (es == `CMP_EDGE_BOTH || es[0] == res)) fl = 1'b1;
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    logic [31:0] r;
    logic e;
    {en, rs, fl, ie, pe, rt, res, es} = '0;
    r = $urandom(38);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(ctrl_a);
    rd(opt_a);
    apb(1'b0, 12'h008, 8'h00, r, e);
    cmp_bit(e, 1'b1);
    $display("test reset done");
    for (int m = 0; m < 4; m++) begin
      @(posedge pclk);
      power_mode <= m == 1 ? PWR_WAIT : (m == 2 ? PWR_DEBUG : PWR_RUN);
      // debug pin assumed released before the result pin is used
      wr(ctrl_a, 8'h94 | 8'(m));
      drive(16'(600 + $urandom_range(400)));
      rd(ctrl_a);
      wr(ctrl_a, 8'h94 | 8'(m));
      rd(ctrl_a);
      drive(16'($urandom_range(400)));
      rd(ctrl_a);
      wr(ctrl_a, 8'hB4 | 8'(m));
      rd(ctrl_a);
    end
    $display("test edge modes done");
    @(posedge pclk);
    power_mode <= PWR_STOP_LIGHT;
    drive(16'h03E8);
    drive(16'h0000);
    @(posedge pclk);
    power_mode <= PWR_RUN;
    rd(ctrl_a);
    drive(16'h03E8);
    @(posedge pclk);
    power_mode <= PWR_STOP_LIGHT;
    @(negedge pclk);
    cmp_bit(irq, 1'b0);
    @(posedge pclk);
    power_mode <= PWR_RUN;
    rd(ctrl_a);
    @(posedge pclk);
    power_mode <= PWR_STOP_DEEP;
    repeat (2) @(posedge pclk);
    power_mode <= PWR_RUN;
    {en, rs, fl, ie, pe, rt, res, es} = '0;
    rd(ctrl_a);
    $display("test stop modes done");
    wr(opt_a, 8'h01);
    // bandgap buffer taken as already on
    wr(ctrl_a, 8'hC1);
    drive(16'h0000);
    rd(ctrl_a);
    rd(opt_a);
    wr(ctrl_a, 8'h01);
    rd(ctrl_a);
    $display("test reference and route done");
    results();
  end
endmodule // tb
bind comparator_control comparator_checker chk (.*);
